// ---- design/psd_decoder.sv ----
`timescale 1ns/100ps
// Summary of operation
// R1 - 128 slots of 4 KB from 0x4000_0000
// R2 - Cleared clock gate bit disables slot
// R3 - Empty or disabled slot gives transfer error
// R4 - Unimplemented offset in slot gives error
// R5 - Occupied slots, first group as listed
// R6 - Occupied slots, second group as listed
// R7 - Master reads back writes needing ordering
// R8 - Private bus refuses all but the core
// R9 - Private bus decoded in seven 4 KB windows
// R10 - GPIO region at 0x400F_F000, core/DMA only
// R11 - Bridge space reachable by core/DMA only
// R12 - Error answers like completion, no side effect
module psd_decoder
  import psd_pkg::*;
#(
  parameter int IMPL_BYTES = 256
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire psd_req_t              req,
  input  wire logic [SLOT_COUNT-1:0] slot_clock_gate,
  input  wire logic [SLOT_COUNT-1:0] slot_rsp_done,
  input  wire logic                  gpio_rsp_done,
  input  wire logic [PRIV_TARGETS-1:0] priv_rsp_done,
  output logic [SLOT_COUNT-1:0]      slot_sel,
  output logic                       gpio_sel,
  output logic [PRIV_TARGETS-1:0]    priv_sel,
  output logic                       periph_write,
  output psd_rsp_t                   rsp
);

  // Elaboration check: the offset compare only covers one 4 KB slot
  if (IMPL_BYTES < 4 || IMPL_BYTES > 4096 || (IMPL_BYTES % 4) != 0) begin : gen_impl_check
    $error("IMPL_BYTES must be a multiple of 4 between 4 and 4096");
  end

  // ==========================================================
  // Address decode
  // ==========================================================
  logic                 in_bridge;
  logic                 in_gpio;
  logic                 in_priv;
  logic                 core_or_dma;
  logic [SLOT_BITS-1:0] slot_idx;
  logic [WIN_BITS-1:0]  win_idx;
  logic [11:0]          offset;
  logic                 offset_ok;

  assign in_bridge   = req.addr >= BRIDGE_BASE && req.addr <= BRIDGE_LAST; // R1
  assign in_gpio     = req.addr[31:SLOT_SHIFT] == GPIO_BASE[31:SLOT_SHIFT]; // R10
  assign in_priv     = req.addr >= PRIV_BASE && req.addr <= PRIV_LAST;
  assign core_or_dma = req.master == PSD_MASTER_CORE || req.master == PSD_MASTER_DMA;
  assign slot_idx    = req.addr[SLOT_SHIFT+SLOT_BITS-1:SLOT_SHIFT]; // R1
  assign win_idx     = req.addr[SLOT_SHIFT+WIN_BITS-1:SLOT_SHIFT];
  assign offset      = req.addr[SLOT_SHIFT-1:0];
  // Only the low implemented range of a slot answers normally
  assign offset_ok   = 32'(offset) < IMPL_BYTES; // R4

  // Private window hit vector, order matches priv_sel bits
  logic [PRIV_TARGETS-1:0] win_hit;
  assign win_hit = {win_idx == WIN_ROM_TABLE,  win_idx == WIN_MISC_CTRL,
                    win_idx == WIN_TRACE_PORT, win_idx == WIN_SYS_CTRL,
                    win_idx == WIN_PATCH,      win_idx == WIN_WATCHPOINT,
                    win_idx == WIN_TRACE_MAC}; // R9

  // ==========================================================
  // Routing decision
  // ==========================================================
  logic                    route_ok;
  logic [SLOT_COUNT-1:0]   slot_hit;
  logic                    gpio_hit;
  logic [PRIV_TARGETS-1:0] priv_hit;

  // Every refusal is decided here so no target ever sees an erroring access
  always_comb begin
    slot_hit = '0;
    gpio_hit = 1'b0;
    priv_hit = '0;
    route_ok = 1'b0;
    if (in_bridge && core_or_dma) begin // R11
      if (OCCUPIED_SLOTS[slot_idx] && slot_clock_gate[slot_idx] && offset_ok) begin // R2 R3 R5 R6
        slot_hit[slot_idx] = 1'b1;
        route_ok           = 1'b1;
      end
    end else if (in_gpio && core_or_dma) begin // R10
      gpio_hit = 1'b1;
      route_ok = 1'b1;
    end else if (in_priv && req.master == PSD_MASTER_CORE) begin // R8
      priv_hit = win_hit; // R9
      route_ok = |win_hit;
    end
  end

  // ==========================================================
  // Transfer state
  // ==========================================================
  typedef enum {PSD_IDLE, PSD_BUSY, PSD_ERROR} psd_state_t;
  psd_state_t              state_q, state_d;
  logic [SLOT_COUNT-1:0]   slot_sel_q, slot_sel_d;
  logic                    gpio_sel_q, gpio_sel_d;
  logic [PRIV_TARGETS-1:0] priv_sel_q, priv_sel_d;
  logic                    write_q, write_d;
  logic                    target_done;

  // Forwarded selects are held until the target completes
  assign target_done = (|(slot_sel_q & slot_rsp_done)) | (gpio_sel_q & gpio_rsp_done) |
                       (|(priv_sel_q & priv_rsp_done));

  always_comb begin
    state_d    = state_q;
    slot_sel_d = slot_sel_q;
    gpio_sel_d = gpio_sel_q;
    priv_sel_d = priv_sel_q;
    write_d    = write_q;
    case (state_q)
      PSD_IDLE: begin
        if (req.valid) begin
          if (route_ok) begin
            state_d    = PSD_BUSY;
            slot_sel_d = slot_hit;
            gpio_sel_d = gpio_hit;
            priv_sel_d = priv_hit;
            write_d    = req.write;
          end else begin
            state_d = PSD_ERROR; // R3 R12
          end
        end
      end
      PSD_BUSY: begin
        if (target_done) begin
          state_d    = PSD_IDLE;
          slot_sel_d = '0;
          gpio_sel_d = 1'b0;
          priv_sel_d = '0;
          write_d    = 1'b0;
        end
      end
      PSD_ERROR: state_d = PSD_IDLE;
      default:   state_d = PSD_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q    <= PSD_IDLE;
      slot_sel_q <= '0;
      gpio_sel_q <= 1'b0;
      priv_sel_q <= '0;
      write_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      slot_sel_q <= slot_sel_d;
      gpio_sel_q <= gpio_sel_d;
      priv_sel_q <= priv_sel_d;
      write_q    <= write_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign slot_sel     = slot_sel_q;
  assign gpio_sel     = gpio_sel_q;
  assign priv_sel     = priv_sel_q;
  assign periph_write = write_q; // R12
  // Error ends on the same response pulse as a normal completion
  assign rsp = '{done:  (state_q == PSD_BUSY && target_done) || state_q == PSD_ERROR, // R12
                 error: state_q == PSD_ERROR}; // R3 R4 R12

  // ==========================================================
  // Checks
  // ==========================================================
  disabled_slot_a: assert property (@(posedge clock) disable iff (!resetn) // R2
    state_q == PSD_IDLE && req.valid && in_bridge && !slot_clock_gate[slot_idx]
    |=> rsp.error && rsp.done && slot_sel == '0)
    else $error("disabled slot not refused");

  empty_slot_a: assert property (@(posedge clock) disable iff (!resetn) // R3
    state_q == PSD_IDLE && req.valid && in_bridge && !OCCUPIED_SLOTS[slot_idx]
    |=> rsp.error)
    else $error("empty slot not refused");

  bad_offset_a: assert property (@(posedge clock) disable iff (!resetn) // R4
    state_q == PSD_IDLE && req.valid && in_bridge && !offset_ok |=> rsp.error)
    else $error("unimplemented offset not refused");

  slot_route_a: assert property (@(posedge clock) disable iff (!resetn) // R1
    state_q == PSD_IDLE && req.valid && in_bridge && core_or_dma &&
    OCCUPIED_SLOTS[slot_idx] && slot_clock_gate[slot_idx] && offset_ok
    |=> slot_sel[$past(slot_idx)] && $onehot(slot_sel) && !rsp.error)
    else $error("slot select wrong");

  occupied_map_a: assert property (@(posedge clock) disable iff (!resetn) // R5
    state_q == PSD_IDLE && req.valid && in_bridge && core_or_dma && offset_ok &&
    slot_clock_gate[slot_idx] && slot_idx < 7'h3C
    |=> rsp.error != $past(slot_idx inside {7'h08, 7'h09, [7'h1F:7'h21], 7'h27, 7'h2C,
                                            7'h32, [7'h36:7'h3B]}))
    else $error("first slot group decoded wrong");

  occupied_hi_a: assert property (@(posedge clock) disable iff (!resetn) // R6
    state_q == PSD_IDLE && req.valid && in_bridge && core_or_dma && offset_ok &&
    slot_clock_gate[slot_idx] && slot_idx >= 7'h3C
    |=> rsp.error != $past(slot_idx inside {[7'h3F:7'h40], [7'h47:7'h4D], 7'h52, 7'h61,
                                            [7'h64:7'h66], 7'h6A, 7'h6B, 7'h73, 7'h74,
                                            [7'h7C:7'h7F]}))
    else $error("second slot group decoded wrong");

  priv_master_a: assert property (@(posedge clock) disable iff (!resetn) // R8
    state_q == PSD_IDLE && req.valid && in_priv && req.master != PSD_MASTER_CORE
    |=> rsp.error && priv_sel == '0)
    else $error("private bus open to non-core master");

  priv_window_a: assert property (@(posedge clock) disable iff (!resetn) // R9
    state_q == PSD_IDLE && req.valid && in_priv && req.master == PSD_MASTER_CORE &&
    win_idx == WIN_SYS_CTRL |=> priv_sel[3] && !rsp.error)
    else $error("system control window not routed");

  gpio_master_a: assert property (@(posedge clock) disable iff (!resetn) // R10
    state_q == PSD_IDLE && req.valid && in_gpio
    |=> (gpio_sel == $past(core_or_dma)) && (rsp.error != $past(core_or_dma)))
    else $error("gpio access rights wrong");

  bridge_master_a: assert property (@(posedge clock) disable iff (!resetn) // R11
    state_q == PSD_IDLE && req.valid && in_bridge && req.master == PSD_MASTER_OTHER
    |=> rsp.error && rsp.done)
    else $error("bridge open to other master");

  error_pulse_a: assert property (@(posedge clock) disable iff (!resetn) // R12
    rsp.error |-> rsp.done && slot_sel == '0 && priv_sel == '0 && !gpio_sel ##1 !rsp.done)
    else $error("error answer malformed");

endmodule : psd_decoder

// ---- shared/psd_pkg.sv ----
package psd_pkg;

  // ==========================================================
  // Address map
  // ==========================================================
  localparam logic [31:0] BRIDGE_BASE     = 32'h4000_0000;
  localparam logic [31:0] BRIDGE_LAST     = 32'h4007_FFFF;
  localparam logic [31:0] GPIO_BASE       = 32'h400F_F000;
  localparam logic [31:0] PRIV_BASE       = 32'hE000_0000;
  localparam logic [31:0] PRIV_LAST       = 32'hE00F_FFFF;
  localparam int          SLOT_COUNT      = 128;
  localparam int          SLOT_BITS       = 7;
  localparam int          SLOT_SHIFT      = 12;
  localparam int          WIN_BITS        = 8;

  // Private bus 4 KB window indices (address bits 19:12)
  localparam logic [7:0] WIN_TRACE_MAC    = 8'h00;
  localparam logic [7:0] WIN_WATCHPOINT   = 8'h01;
  localparam logic [7:0] WIN_PATCH        = 8'h02;
  localparam logic [7:0] WIN_SYS_CTRL     = 8'h0E;
  localparam logic [7:0] WIN_TRACE_PORT   = 8'h40;
  localparam logic [7:0] WIN_MISC_CTRL    = 8'h80;
  localparam logic [7:0] WIN_ROM_TABLE    = 8'hFF;
  localparam int         PRIV_TARGETS     = 7;

  // Occupied bridge slots, one bit per slot
  localparam logic [127:0] OCCUPIED_SLOTS =
      (128'h1 << 8)  | (128'h1 << 9)  | (128'h1 << 31) | (128'h1 << 32) |
      (128'h1 << 33) | (128'h1 << 39) | (128'h1 << 44) | (128'h1 << 50) |
      (128'h1F << 54) | (128'h1 << 59) | (128'h1 << 63) | (128'h1 << 64) |
      (128'h1 << 71) | (128'h1 << 72) | (128'h1F << 73) | (128'h1 << 82) |
      (128'h1 << 97) | (128'h1 << 100) | (128'h1 << 101) | (128'h1 << 102) |
      (128'h1 << 106) | (128'h1 << 107) | (128'h1 << 115) | (128'h1 << 116) |
      (128'hF << 124);

  // Bus masters
  typedef enum logic [1:0] {
    PSD_MASTER_CORE  = 2'h0,
    PSD_MASTER_DMA   = 2'h1,
    PSD_MASTER_OTHER = 2'h2
  } psd_master_t;

  // Request from a master
  typedef struct packed {
    logic        valid;
    logic        write;
    psd_master_t master;
    logic [31:0] addr;
  } psd_req_t;

  // Answer to a master
  typedef struct packed {
    logic done;
    logic error;
  } psd_rsp_t;

endpackage : psd_pkg

// ---- verification/psd_target_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// Peripheral responder: completes any selected access after a set latency
module psd_target_model
  import psd_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic [3:0]              latency,
  input  wire logic [SLOT_COUNT-1:0]   slot_sel,
  input  wire logic                    gpio_sel,
  input  wire logic [PRIV_TARGETS-1:0] priv_sel,
  output logic [SLOT_COUNT-1:0]        slot_rsp_done,
  output logic                         gpio_rsp_done,
  output logic [PRIV_TARGETS-1:0]      priv_rsp_done
);
  logic [3:0] wait_q;
  logic [3:0] wait_d;
  logic       any_sel;
  logic       hit;

  // Done only while selected, so a stray pulse never completes an idle decoder
  always_comb begin
    any_sel       = (|slot_sel) | gpio_sel | (|priv_sel);
    hit           = any_sel && (wait_q == latency);
    wait_d        = (any_sel && !hit) ? wait_q + 4'h1 : 4'h0;
    slot_rsp_done = slot_sel & {SLOT_COUNT{hit}};
    gpio_rsp_done = gpio_sel & hit;
    priv_rsp_done = priv_sel & {PRIV_TARGETS{hit}};
  end

  // Wait counter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_d;
    end
  end
endmodule : psd_target_model

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top
  import psd_pkg::*;
;
  localparam int IMPL = 256;
  logic                    clock = 1'b0;
  logic                    resetn;
  psd_req_t                req;
  psd_rsp_t                rsp;
  logic [127:0]            gate;
  logic [3:0]              latency;
  logic [127:0]            slot_sel, slot_done;
  logic                    gpio_sel, gpio_done, periph_write;
  logic [6:0]              priv_sel, priv_done;
  logic [15:0]             lfsr;
  int                      errors = 0;
  int                      check_count = 0;
  logic [7:0]              wins [7] = '{WIN_TRACE_MAC, WIN_WATCHPOINT, WIN_PATCH,
                                        WIN_SYS_CTRL, WIN_TRACE_PORT, WIN_MISC_CTRL,
                                        WIN_ROM_TABLE};
  logic [31:0]             corner [10] = '{32'h4000_80FF, 32'h4000_8100, 32'h4007_FFFC,
                                          32'h4008_0000, GPIO_BASE, 32'h400F_EFFC,
                                          32'hE000_3000, 32'hE010_0000, 32'h0000_0000,
                                          32'hE00F_F000};

  always #5 clock = ~clock;

  psd_decoder #(.IMPL_BYTES(IMPL)) psd_decoder_inst (.clock(clock), .resetn(resetn),
    .req(req), .slot_clock_gate(gate), .slot_rsp_done(slot_done),
    .gpio_rsp_done(gpio_done), .priv_rsp_done(priv_done), .slot_sel(slot_sel),
    .gpio_sel(gpio_sel), .priv_sel(priv_sel), .periph_write(periph_write), .rsp(rsp));

  psd_target_model psd_target_model_inst (.clock(clock), .resetn(resetn),
    .latency(latency), .slot_sel(slot_sel), .gpio_sel(gpio_sel), .priv_sel(priv_sel),
    .slot_rsp_done(slot_done), .gpio_rsp_done(gpio_done), .priv_rsp_done(priv_done));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  // Expected {error, write, priv, gpio, slot}; anything unselected is refused
  function automatic logic [137:0] predict(input logic [1:0] m, input logic [31:0] a,
                                           input logic w);
    logic [127:0] s;
    logic [6:0]   p;
    logic         g;
    s = '0;
    p = '0;
    if (m < 2'h2 && a >= BRIDGE_BASE && a <= BRIDGE_LAST && OCCUPIED_SLOTS[a[18:12]]
        && gate[a[18:12]] && a[11:0] < IMPL) s[a[18:12]] = 1'b1;
    g = (m < 2'h2) && (a[31:12] == GPIO_BASE[31:12]);
    for (int i = 0; i < 7; i++) p[i] = (m == 2'h0) && (a[31:12] == {12'hE00, wins[i]});
    return (s == '0 && !g && p == '0) ? {1'b1, 137'h0} : {1'b0, w, p, g, s};
  endfunction : predict

  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One held request; outputs sampled at the falling edge of the done cycle
  task automatic access(input logic [1:0] m, input logic [31:0] a, input logic w);
    logic [137:0] exp;
    int           n;
    exp = predict(m, a, w);
    @(posedge clock);
    #1 req = '{valid: 1'b1, write: w, master: psd_master_t'(m), addr: a};
    @(negedge clock);
    for (n = 0; n < 40 && rsp.done !== 1'b1; n++) @(negedge clock);
    check({6'(n), rsp.error, periph_write, priv_sel, gpio_sel, slot_sel},
          {exp[137] ? 6'h1 : 6'h1 + 6'(latency), exp});
    @(posedge clock);
    #1 req.valid = 1'b0;
  endtask : access

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] r, s, o;
    logic [1:0]  m;
    logic [31:0] a;
    lfsr = 16'h0023;
    req = '0;
    gate = '1;
    latency = 4'h0;
    resetn = 1'b0;
    repeat (8) @(posedge clock);
    #1 resetn = 1'b1;
    for (int k = 0; k < 256; k++) begin
      gate = k[7] ? 128'h0 : {128{1'b1}};
      access(2'h0, BRIDGE_BASE + {k[6:0], 12'h000}, 1'b1);
    end
    gate = '1;
    for (int k = 0; k < 40; k++) access(k[1:0], corner[k / 4], 1'b0);
    for (int k = 0; k < 14; k++) access({1'b0, k[0]}, {12'hE00, wins[k / 2], 12'h0}, 1'b1);
    // Random traffic; every write is read back, as a careful master does
    for (int k = 0; k < 300; k++) begin
      r = rnd();
      s = rnd();
      o = rnd();
      gate = {8{rnd()}};
      latency = {2'b0, r[1:0]};
      m = (r[7:5] == 3'h0) ? 2'h2 : {1'b0, r[8]};
      case (r[3:2])
        2'h2: a = {12'hE00, r[4] ? wins[s[10:8] % 7] : s[7:0], 12'h0};
        2'h3: a = GPIO_BASE | {20'h0, o[11:2], 2'b0};
        default: a = BRIDGE_BASE | {13'h0, s[6:0], 3'h0, o[8:0]};
      endcase
      access(m, a, 1'b1);
      access(m, a, 1'b0);
    end
    // Reset in mid access must drop every select and answer at once
    gate = {128{1'b1}};
    latency = 4'hF;
    @(posedge clock);
    #1 req = '{valid: 1'b1, write: 1'b1, master: PSD_MASTER_CORE,
               addr: BRIDGE_BASE | 32'h0000_8000};
    @(negedge clock);
    @(negedge clock);
    check({slot_sel[8], periph_write, rsp.done}, 3'h6);
    @(posedge clock);
    #1 resetn = 1'b0;
    req = '0;
    @(negedge clock);
    check({rsp, periph_write, priv_sel, gpio_sel, slot_sel}, 144'h0);
    @(posedge clock);
    #1 resetn = 1'b1;
    latency = 4'h0;
    access(2'h0, BRIDGE_BASE | 32'h0000_8000, 1'b0);
    wrap_up();
  end

  // Hang guard, far beyond the expected run time
  initial begin
    #400000;
    errors++;
    wrap_up();
  end
endmodule : tb_top
